// [logic/lcp_defines.svh]
// constants of the line-codec indirect parameter bank
// assumes an AXI4-Lite master with 8-bit byte addresses, word index = addr[7:2]
`ifndef LCP_DEFINES_SVH
`define LCP_DEFINES_SVH
`define LCP_ADDR_W 8
`define LCP_WORD_W 16
`define LCP_NREG 31
`define LCP_IDX_FIRST 6'd13
`define LCP_IDX_LAST 6'd43
`define LCP_IDX_T1_FREQ 6'd13
`define LCP_IDX_T1_AMP 6'd14
`define LCP_IDX_T1_PHASE 6'd15
`define LCP_IDX_T2_FREQ 6'd16
`define LCP_IDX_T2_AMP 6'd17
`define LCP_IDX_T2_PHASE 6'd18
`define LCP_IDX_RING_OFF 6'd19
`define LCP_IDX_RING_FREQ 6'd20
`define LCP_IDX_RING_AMP 6'd21
`define LCP_IDX_RING_PHASE 6'd22
`define LCP_IDX_MTR_RAMP 6'd23
`define LCP_IDX_MTR_AMP 6'd24
`define LCP_IDX_MTR_FREQ 6'd25
`define LCP_IDX_RX_GAIN 6'd26
`define LCP_IDX_TX_GAIN 6'd27
`define LCP_IDX_LC_UPPER 6'd28
`define LCP_IDX_RT_THR 6'd29
`define LCP_IDX_CM_LOW 6'd30
`define LCP_IDX_CM_HIGH 6'd31
`define LCP_IDX_PWR_A 6'd32
`define LCP_IDX_PWR_B 6'd33
`define LCP_IDX_PWR_C 6'd34
`define LCP_IDX_LC_FILT 6'd35
`define LCP_IDX_RT_FILT 6'd36
`define LCP_IDX_POLE_A 6'd37
`define LCP_IDX_POLE_B 6'd38
`define LCP_IDX_POLE_C 6'd39
`define LCP_IDX_CM_BIAS 6'd40
`define LCP_IDX_OVERHEAD 6'd41
`define LCP_IDX_SPARE 6'd42
`define LCP_IDX_LC_LOWER 6'd43
`define LCP_FIELD_LSB 0
`define LCP_GAIN_MSB 11
`define LCP_SIX_MSB 5
`define LCP_EIGHT_MSB 7
`define LCP_COEF_MSB 12
`define LCP_FOUR_MSB 3
`define LCP_GAIN_FRAC 10
`define LCP_SMP_W 16
`define LCP_RING_STEP_MV 17'd1500
`define LCP_LC_STEP_UA 17'd1270
`define LCP_RESP_OKAY 2'b00
`define LCP_RESP_SLVERR 2'b10
`endif

// [logic/lcp_pkg.sv]
// types of the line-codec indirect parameter bank
// assumes lcp_defines.svh sits on the include path
package lcp_pkg;
  `include "lcp_defines.svh"

  typedef struct packed {
    logic valid;
    logic signed [`LCP_SMP_W-1:0] data;
  } lcp_sample_t;

  typedef struct packed {
    logic signed [`LCP_WORD_W-1:0] freq;
    logic signed [`LCP_WORD_W-1:0] amp;
    logic signed [`LCP_WORD_W-1:0] phase;
  } lcp_osc_t;

  typedef struct packed {
    logic signed [`LCP_WORD_W-1:0] ramp;
    logic signed [`LCP_WORD_W-1:0] amp;
    logic signed [`LCP_WORD_W-1:0] freq;
  } lcp_meter_t;

  typedef struct packed {
    logic [`LCP_SIX_MSB:0] ring_trip;
    logic [`LCP_SIX_MSB:0] cm_low;
    logic [`LCP_SIX_MSB:0] cm_high;
    logic [`LCP_EIGHT_MSB:0] pwr_a;
    logic [`LCP_EIGHT_MSB:0] pwr_b;
    logic [`LCP_EIGHT_MSB:0] pwr_c;
    logic [`LCP_COEF_MSB:0] lc_filt;
    logic [`LCP_COEF_MSB:0] rt_filt;
    logic [`LCP_COEF_MSB:0] pole_a;
    logic [`LCP_COEF_MSB:0] pole_b;
    logic [`LCP_COEF_MSB:0] pole_c;
    logic [`LCP_FOUR_MSB:0] cm_bias;
    logic [`LCP_FOUR_MSB:0] overhead;
  } lcp_line_t;

  typedef enum logic [1:0] {
    LCP_WR_IDLE = 2'b00,
    LCP_WR_HALF = 2'b01,
    LCP_WR_RESP = 2'b11
  } lcp_wr_t;

  typedef enum logic {
    LCP_RD_IDLE = 1'b0,
    LCP_RD_DATA = 1'b1
  } lcp_rd_t;

  typedef struct packed {
    lcp_wr_t wr;
    lcp_rd_t rd;
    logic awready;
    logic wready;
    logic aw_have;
    logic [`LCP_ADDR_W-1:0] aw_addr;
    logic w_have;
    logic [`LCP_WORD_W-1:0] w_data;
    logic [1:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [`LCP_NREG-1:0][`LCP_WORD_W-1:0] bank;
    lcp_sample_t rx;
    lcp_sample_t tx;
    logic [16:0] ring_off_mv;
    logic [16:0] lc_upper_ua;
    logic loop_closed;
  } lcp_state_t;
endpackage : lcp_pkg

// [logic/lcp_param_bank.sv]
// indirect parameter bank: oscillator, gain and line-control words behind AXI4-Lite
// assumes one clock, synchronous active-low reset, samples synchronous to aclk
`timescale 1ns/1ps
`include "lcp_defines.svh"
module lcp_param_bank (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [`LCP_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`LCP_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire lcp_pkg::lcp_sample_t rx_in,
  output lcp_pkg::lcp_sample_t rx_out,
  input wire lcp_pkg::lcp_sample_t tx_in,
  output lcp_pkg::lcp_sample_t tx_out,
  output lcp_pkg::lcp_osc_t tone1,
  output lcp_pkg::lcp_osc_t tone2,
  output lcp_pkg::lcp_osc_t ring,
  output lcp_pkg::lcp_meter_t meter,
  output lcp_pkg::lcp_line_t line_ctl,
  output logic [16:0] ring_offset_mv,
  output logic [16:0] loop_upper_ua,
  input wire logic [`LCP_SIX_MSB:0] loop_sense,
  input wire logic loop_hyst_en,
  output logic loop_closed
);
  import lcp_pkg::*;

  localparam int B_RXG = int'(`LCP_IDX_RX_GAIN - `LCP_IDX_FIRST);
  localparam int B_TXG = int'(`LCP_IDX_TX_GAIN - `LCP_IDX_FIRST);
  localparam int B_RING_DC_OFFSET = int'(`LCP_IDX_RING_OFF - `LCP_IDX_FIRST);
  localparam int B_LCU = int'(`LCP_IDX_LC_UPPER - `LCP_IDX_FIRST);
  localparam int B_LCL = int'(`LCP_IDX_LC_LOWER - `LCP_IDX_FIRST);
  localparam int B_CMB = int'(`LCP_IDX_CM_BIAS - `LCP_IDX_FIRST);

  lcp_state_t st;
  lcp_state_t next_st;

  // address falls inside the bank, spare location included
  function automatic logic bank_hit(input logic [`LCP_ADDR_W-1:0] a);
    bank_hit = (a[7:2] >= `LCP_IDX_FIRST) && (a[7:2] <= `LCP_IDX_LAST);
  endfunction : bank_hit

  // word slot within the packed bank
  function automatic logic [4:0] slot(input logic [`LCP_ADDR_W-1:0] a);
    logic [5:0] d;
    d = a[7:2] - `LCP_IDX_FIRST;
    slot = d[4:0];
  endfunction : slot

  // signed multiply, 0x400 is unity; saturate instead of wrapping on overdrive
  function automatic lcp_sample_t scale(input lcp_sample_t s, input logic [`LCP_WORD_W-1:0] g);
    logic signed [27:0] p;
    logic signed [27:0] sh;
    logic [17:0] q;
    lcp_sample_t o;
    p = s.data * $signed(g[`LCP_GAIN_MSB:`LCP_FIELD_LSB]);
    sh = p >>> `LCP_GAIN_FRAC;
    q = sh[17:0];
    o.valid = s.valid;
    if (q[17:15] != {3{q[15]}}) begin
      o.data = q[17] ? 16'sh8000 : 16'sh7fff;
    end else begin
      o.data = q[15:0];
    end
    scale = o;
  endfunction : scale

  // whole next state; bank words are never reset
  always_comb begin
    next_st = st;
    // write address and data are taken independently
    if (s_axi_awvalid && st.awready) begin
      next_st.aw_have = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
      next_st.awready = 1'b0;
    end
    if (s_axi_wvalid && st.wready) begin
      next_st.w_have = 1'b1;
      next_st.w_data = s_axi_wdata[15:0];
      next_st.w_strb = s_axi_wstrb[1:0];
      next_st.wready = 1'b0;
    end
    case (st.wr)
      LCP_WR_IDLE, LCP_WR_HALF: begin
        if (next_st.aw_have && next_st.w_have) begin
          next_st.bvalid = 1'b1;
          next_st.aw_have = 1'b0;
          next_st.w_have = 1'b0;
          next_st.wr = LCP_WR_RESP;
          if (bank_hit(next_st.aw_addr)) begin
            next_st.bresp = `LCP_RESP_OKAY;
            // every bit kept as written, spare word too
            if (next_st.w_strb[0]) begin
              next_st.bank[slot(next_st.aw_addr)][7:0] = next_st.w_data[7:0];
            end
            if (next_st.w_strb[1]) begin
              next_st.bank[slot(next_st.aw_addr)][15:8] = next_st.w_data[15:8];
            end
          end else begin
            next_st.bresp = `LCP_RESP_SLVERR;
          end
        end else if (next_st.aw_have || next_st.w_have) begin
          next_st.wr = LCP_WR_HALF;
        end
      end
      LCP_WR_RESP: begin
        if (s_axi_bready) begin
          next_st.bvalid = 1'b0;
          next_st.awready = 1'b1;
          next_st.wready = 1'b1;
          next_st.wr = LCP_WR_IDLE;
        end
      end
      default: begin
        next_st.wr = LCP_WR_IDLE;
      end
    endcase
    // read channel: one read in flight, data latched at address handshake
    case (st.rd)
      LCP_RD_IDLE: begin
        if (s_axi_arvalid && st.arready) begin
          next_st.arready = 1'b0;
          next_st.rvalid = 1'b1;
          next_st.rd = LCP_RD_DATA;
          if (bank_hit(s_axi_araddr)) begin
            next_st.rdata = {16'h0000, st.bank[slot(s_axi_araddr)]};
            next_st.rresp = `LCP_RESP_OKAY;
          end else begin
            next_st.rdata = 32'h0000_0000;
            next_st.rresp = `LCP_RESP_SLVERR;
          end
        end
      end
      LCP_RD_DATA: begin
        if (s_axi_rready) begin
          next_st.rvalid = 1'b0;
          next_st.arready = 1'b1;
          next_st.rd = LCP_RD_IDLE;
        end
      end
      default: begin
        next_st.rd = LCP_RD_IDLE;
      end
    endcase
    // audio paths, one cycle through
    next_st.rx = scale(rx_in, st.bank[B_RXG]);
    next_st.tx = scale(tx_in, st.bank[B_TXG]);
    // physical readouts of the threshold codes
    next_st.ring_off_mv = 17'(st.bank[B_RING_DC_OFFSET][`LCP_SIX_MSB:0] * `LCP_RING_STEP_MV);
    next_st.lc_upper_ua = 17'(st.bank[B_LCU][`LCP_SIX_MSB:0] * `LCP_LC_STEP_UA);
    // loop detector: hysteresis uses both bounds, otherwise upper alone
    if (loop_hyst_en) begin
      if (!st.loop_closed && loop_sense > st.bank[B_LCU][`LCP_SIX_MSB:0]) begin
        next_st.loop_closed = 1'b1;
      end else if (st.loop_closed && loop_sense < st.bank[B_LCL][`LCP_SIX_MSB:0]) begin
        next_st.loop_closed = 1'b0;
      end
    end else begin
      next_st.loop_closed = loop_sense > st.bank[B_LCU][`LCP_SIX_MSB:0];
    end
    // control state, rx/tx sample registers and loop_closed only; parameter words keep whatever they held
    if (!aresetn) begin
      next_st.wr = LCP_WR_IDLE;
      next_st.rd = LCP_RD_IDLE;
      next_st.awready = 1'b1;
      next_st.wready = 1'b1;
      next_st.aw_have = 1'b0;
      next_st.w_have = 1'b0;
      next_st.bvalid = 1'b0;
      next_st.bresp = `LCP_RESP_OKAY;
      next_st.arready = 1'b1;
      next_st.rvalid = 1'b0;
      next_st.rresp = `LCP_RESP_OKAY;
      next_st.rdata = 32'h0000_0000;
      next_st.rx = '0;
      next_st.tx = '0;
      next_st.loop_closed = 1'b0;
    end
  end

  // the single state register
  always_ff @(posedge aclk) begin
    st <= next_st;
  end

  // bus outputs straight from state
  assign s_axi_awready = st.awready;
  assign s_axi_wready = st.wready;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = st.arready;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rresp = st.rresp;
  assign s_axi_rdata = st.rdata;
  assign rx_out = st.rx;
  assign tx_out = st.tx;
  assign ring_offset_mv = st.ring_off_mv;
  assign loop_upper_ua = st.lc_upper_ua;
  assign loop_closed = st.loop_closed;

  // generator words, taken as signed
  assign tone1.freq = st.bank[`LCP_IDX_T1_FREQ - `LCP_IDX_FIRST];
  assign tone1.amp = st.bank[`LCP_IDX_T1_AMP - `LCP_IDX_FIRST];
  assign tone1.phase = st.bank[`LCP_IDX_T1_PHASE - `LCP_IDX_FIRST];
  assign tone2.freq = st.bank[`LCP_IDX_T2_FREQ - `LCP_IDX_FIRST];
  assign tone2.amp = st.bank[`LCP_IDX_T2_AMP - `LCP_IDX_FIRST];
  assign tone2.phase = st.bank[`LCP_IDX_T2_PHASE - `LCP_IDX_FIRST];
  assign ring.freq = st.bank[`LCP_IDX_RING_FREQ - `LCP_IDX_FIRST];
  assign ring.amp = st.bank[`LCP_IDX_RING_AMP - `LCP_IDX_FIRST];
  assign ring.phase = st.bank[`LCP_IDX_RING_PHASE - `LCP_IDX_FIRST];
  assign meter.ramp = st.bank[`LCP_IDX_MTR_RAMP - `LCP_IDX_FIRST];
  assign meter.amp = st.bank[`LCP_IDX_MTR_AMP - `LCP_IDX_FIRST];
  assign meter.freq = st.bank[`LCP_IDX_MTR_FREQ - `LCP_IDX_FIRST];

  // line-control fields sit in the low bits of their words
  assign line_ctl.ring_trip = st.bank[`LCP_IDX_RT_THR - `LCP_IDX_FIRST][`LCP_SIX_MSB:0];
  assign line_ctl.cm_low = st.bank[`LCP_IDX_CM_LOW - `LCP_IDX_FIRST][`LCP_SIX_MSB:0];
  assign line_ctl.cm_high = st.bank[`LCP_IDX_CM_HIGH - `LCP_IDX_FIRST][`LCP_SIX_MSB:0];
  assign line_ctl.pwr_a = st.bank[`LCP_IDX_PWR_A - `LCP_IDX_FIRST][`LCP_EIGHT_MSB:0];
  assign line_ctl.pwr_b = st.bank[`LCP_IDX_PWR_B - `LCP_IDX_FIRST][`LCP_EIGHT_MSB:0];
  assign line_ctl.pwr_c = st.bank[`LCP_IDX_PWR_C - `LCP_IDX_FIRST][`LCP_EIGHT_MSB:0];
  assign line_ctl.lc_filt = st.bank[`LCP_IDX_LC_FILT - `LCP_IDX_FIRST][`LCP_COEF_MSB:0];
  assign line_ctl.rt_filt = st.bank[`LCP_IDX_RT_FILT - `LCP_IDX_FIRST][`LCP_COEF_MSB:0];
  assign line_ctl.pole_a = st.bank[`LCP_IDX_POLE_A - `LCP_IDX_FIRST][`LCP_COEF_MSB:0];
  assign line_ctl.pole_b = st.bank[`LCP_IDX_POLE_B - `LCP_IDX_FIRST][`LCP_COEF_MSB:0];
  assign line_ctl.pole_c = st.bank[`LCP_IDX_POLE_C - `LCP_IDX_FIRST][`LCP_COEF_MSB:0];
  assign line_ctl.cm_bias = st.bank[`LCP_IDX_CM_BIAS - `LCP_IDX_FIRST][`LCP_FOUR_MSB:0];
  assign line_ctl.overhead = st.bank[`LCP_IDX_OVERHEAD - `LCP_IDX_FIRST][`LCP_FOUR_MSB:0];

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // full-word write to one location in a single cycle
  sequence s_wr(logic [5:0] idx);
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready &&
      s_axi_wstrb[1:0] == 2'b11 && s_axi_awaddr[7:2] == idx;
  endsequence

  // read address taken for one location
  sequence s_rd(logic [5:0] idx);
    s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] == idx;
  endsequence

  a_rx_mute: assert property (rx_in.valid && st.bank[B_RXG][11:0] == 12'h000 |=>
    rx_out.valid && rx_out.data == 16'sh0000) else $error("receive mute not zero");
  a_rx_unity: assert property (st.bank[B_RXG][11:0] == 12'h400 |=>
    rx_out.data == $past(rx_in.data)) else $error("receive unity gain altered sample");
  a_tx_unity: assert property (st.bank[B_TXG][11:0] == 12'h400 |=>
    tx_out.data == $past(tx_in.data) && tx_out.valid == $past(tx_in.valid)) else $error("transmit unity wrong");
  a_tx_gain_field: assert property (st.bank[B_TXG][11:0] == 12'hc00 && tx_in.data == 16'sh0100 |=>
    tx_out.data == -16'sh0100) else $error("transmit gain field not signed 12-bit");
  a_t1_map: assert property (s_wr(`LCP_IDX_T1_AMP) |=>
    tone1.amp == $past(s_axi_wdata[15:0])) else $error("tone one amplitude not mapped");
  a_t2_map: assert property (s_wr(`LCP_IDX_T2_PHASE) |=>
    tone2.phase == $past(s_axi_wdata[15:0])) else $error("tone two phase not mapped");
  a_ring_map: assert property (s_wr(`LCP_IDX_RING_FREQ) |=>
    ring.freq == $past(s_axi_wdata[15:0]) && s_axi_bvalid) else $error("ringing frequency not mapped");
  a_meter_map: assert property (s_wr(`LCP_IDX_MTR_RAMP) |=>
    meter.ramp == $past(s_axi_wdata[15:0])) else $error("metering ramp not mapped");
  a_ring_offset: assert property ($stable(st.bank[B_RING_DC_OFFSET]) |=>
    ring_offset_mv == 17'($past(st.bank[B_RING_DC_OFFSET][5:0]) * 17'd1500)) else $error("ring offset scale wrong");
  a_loop_hold: assert property (loop_hyst_en && loop_closed &&
    loop_sense >= st.bank[B_LCL][5:0] |=> loop_closed) else $error("loop opened above lower bound");
  // the read may follow the write response by a few idle cycles
  a_spare_store: assert property (s_wr(`LCP_IDX_SPARE) ##1 s_axi_bvalid && s_axi_bready ##[1:3]
    s_rd(`LCP_IDX_SPARE) |=> s_axi_rvalid && s_axi_rresp == 2'b00) else $error("spare location not readable");
  a_unused_bits: assert property (s_wr(`LCP_IDX_CM_BIAS) |=>
    st.bank[B_CMB] == $past(s_axi_wdata[15:0])) else $error("unused bits lost");
endmodule : lcp_param_bank

// [test/lcp_param_bank_tb.sv]
// bench for the line-codec indirect parameter bank: bus rows, gain table, hand-written edge cases
// assumes lcp_pkg and lcp_param_bank compiled first; bench drives every port itself
`timescale 1ns/1ps
module lcp_param_bank_tb;
  import lcp_pkg::*;
  typedef struct packed {
    logic [5:0] idx;
    logic [31:0] wd;
    logic [31:0] pe;
  } lcp_row_t;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  lcp_sample_t rx_in = '0;
  lcp_sample_t tx_in = '0;
  lcp_sample_t rx_out, tx_out;
  lcp_osc_t tone1, tone2, ring;
  lcp_meter_t meter;
  lcp_line_t line_ctl;
  logic [16:0] ring_offset_mv, loop_upper_ua;
  logic [5:0] loop_sense = 6'h00;
  logic loop_hyst_en = 1'b0;
  logic loop_closed;
  int miscompares = 0;
  int num_checks = 0;
  // upper halves of the write data for rows 13, 15 and 16 are junk on purpose: only the low word may land
  lcp_row_t rows [0:16] = '{
    '{6'd13, 32'hdead8001, 32'h8001}, '{6'd14, 32'h00007fff, 32'h7fff}, '{6'd15, 32'h1111a5a5, 32'ha5a5},
    '{6'd16, 32'hffff0102, 32'h0102}, '{6'd17, 32'h00001357, 32'h1357}, '{6'd18, 32'h00002468, 32'h2468},
    '{6'd20, 32'h00000fed, 32'h0fed}, '{6'd21, 32'h0000c001, 32'hc001}, '{6'd22, 32'h00005aa5, 32'h5aa5},
    '{6'd23, 32'h00000011, 32'h0011}, '{6'd24, 32'h00004242, 32'h4242}, '{6'd25, 32'h00009009, 32'h9009},
    '{6'd29, 32'h0000ffff, 32'h003f}, '{6'd32, 32'h000001ff, 32'h00ff}, '{6'd35, 32'h0000e001, 32'h0001},
    '{6'd40, 32'h000000f5, 32'h0005}, '{6'd42, 32'h0000beef, 32'h0000}};
  // {gain word, sample}: unity, mute, max, saturation, negative gains, ignored upper bits
  logic [31:0] gains [0:6] = '{32'h04000100, 32'h00001234, 32'h07ff0100, 32'h07ff7000, 32'h08000100, 32'hf4008000,
    32'h0c000100};

  lcp_param_bank u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'b000),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'b000), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .rx_in(rx_in), .rx_out(rx_out),
    .tx_in(tx_in), .tx_out(tx_out), .tone1(tone1), .tone2(tone2), .ring(ring), .meter(meter),
    .line_ctl(line_ctl), .ring_offset_mv(ring_offset_mv), .loop_upper_ua(loop_upper_ua),
    .loop_sense(loop_sense), .loop_hyst_en(loop_hyst_en), .loop_closed(loop_closed));

  // 25 MHz core clock
  initial begin
    forever #20 aclk = ~aclk;
  end

  task automatic test_done;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done

  task automatic chk_val(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk_val

  task automatic chk_resp(input string n, input logic [1:0] e, input logic [1:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %b seen %b", n, e, g);
    end
  endtask : chk_resp

  // readies are read mid-cycle so the handshake edge is known before it comes
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    logic ta, tw, tb, busy;
    logic [1:0] resp;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    busy = 1'b1;
    resp = 2'bxx;
    while (busy) begin
      @(negedge aclk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tb = s_axi_bvalid & s_axi_bready;
      if (tb) resp = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) s_axi_bready <= 1'b0;
      busy = ~tb;
    end
    chk_resp("bresp", er, resp);
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ta, tr, busy;
    logic [31:0] d;
    logic [1:0] resp;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    busy = 1'b1;
    d = 32'hx;
    resp = 2'bxx;
    while (busy) begin
      @(negedge aclk);
      ta = s_axi_arvalid & s_axi_arready;
      tr = s_axi_rvalid & s_axi_rready;
      if (tr) d = s_axi_rdata;
      if (tr) resp = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tr) s_axi_rready <= 1'b0;
      busy = ~tr;
    end
    chk_val("rdata", ed, d);
    chk_resp("rresp", er, resp);
  endtask : axi_read

  // observed port value for a bank index, zero-extended; no port means zero
  function automatic logic [31:0] port_word(input logic [5:0] i);
    case (i)
      6'd13: return {16'h0, tone1.freq};
      6'd14: return {16'h0, tone1.amp};
      6'd15: return {16'h0, tone1.phase};
      6'd16: return {16'h0, tone2.freq};
      6'd17: return {16'h0, tone2.amp};
      6'd18: return {16'h0, tone2.phase};
      6'd20: return {16'h0, ring.freq};
      6'd21: return {16'h0, ring.amp};
      6'd22: return {16'h0, ring.phase};
      6'd23: return {16'h0, meter.ramp};
      6'd24: return {16'h0, meter.amp};
      6'd25: return {16'h0, meter.freq};
      6'd29: return {26'h0, line_ctl.ring_trip};
      6'd32: return {24'h0, line_ctl.pwr_a};
      6'd35: return {19'h0, line_ctl.lc_filt};
      6'd40: return {28'h0, line_ctl.cm_bias};
      default: return 32'h0;
    endcase
  endfunction : port_word

  // saturating signed product, gain field taken from bits 11:0 only
  function automatic logic [15:0] scale(input logic [15:0] g, input logic [15:0] s);
    logic signed [31:0] p;
    p = $signed(s) * $signed(g[11:0]);
    p = p >>> 10;
    if (p > 32767) return 16'h7fff;
    if (p < -32768) return 16'h8000;
    return p[15:0];
  endfunction : scale

  task automatic gain_step(input bit tx, input logic [31:0] gs);
    axi_write(tx ? 8'h6c : 8'h68, {16'h0, gs[31:16]}, 4'hf, 2'b00);
    if (tx) tx_in <= '{valid: 1'b1, data: gs[15:0]};
    else rx_in <= '{valid: 1'b1, data: gs[15:0]};
    @(posedge aclk);
    @(negedge aclk);
    if (tx) chk_val("tx_out", {15'h0, 1'b1, scale(gs[31:16], gs[15:0])}, {15'h0, tx_out});
    else chk_val("rx_out", {15'h0, 1'b1, scale(gs[31:16], gs[15:0])}, {15'h0, rx_out});
  endtask : gain_step

  task automatic loop_step(input logic [5:0] s, input logic h, input logic e);
    @(posedge aclk);
    loop_sense <= s;
    loop_hyst_en <= h;
    @(posedge aclk);
    @(negedge aclk);
    chk_val("loop_closed", {31'h0, e}, {31'h0, loop_closed});
  endtask : loop_step

  // hang guard: whole run needs well under 2000 cycles
  initial begin
    repeat (5000) @(posedge aclk);
    miscompares++;
    test_done();
  end

  initial begin
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    chk_val("awready", 32'h1, {31'h0, s_axi_awready});
    chk_val("bvalid", 32'h0, {31'h0, s_axi_bvalid});
    chk_val("rvalid", 32'h0, {31'h0, s_axi_rvalid});
    chk_val("loop_closed", 32'h0, {31'h0, loop_closed});
    @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i]) begin
      axi_write({rows[i].idx, 2'b00}, rows[i].wd, 4'hf, 2'b00);
      axi_read({rows[i].idx, 2'b00}, {16'h0, rows[i].wd[15:0]}, 2'b00);
      chk_val("port", rows[i].pe, port_word(rows[i].idx));
    end
    for (int p = 0; p < 2; p++) begin
      foreach (gains[i]) gain_step(p[0], gains[i]);
    end
    // byte strobe leaves the untouched lane alone
    axi_write(8'h34, 32'h0000abcd, 4'h1, 2'b00);
    axi_read(8'h34, 32'h000080cd, 2'b00);
    // unmapped neighbours on both sides of the bank
    axi_write(8'h30, 32'h00001234, 4'hf, 2'b10);
    axi_read(8'h30, 32'h0, 2'b10);
    axi_write(8'hb0, 32'h00001234, 4'hf, 2'b10);
    axi_read(8'hb0, 32'h0, 2'b10);
    axi_write(8'h4c, 32'h0000003f, 4'hf, 2'b00);
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    chk_val("ring_offset_mv", 32'd94500, {15'h0, ring_offset_mv});
    axi_write(8'h4c, 32'h0000ffc1, 4'hf, 2'b00);
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    chk_val("ring_offset_mv", 32'd1500, {15'h0, ring_offset_mv});
    axi_write(8'h70, 32'h0000000a, 4'hf, 2'b00);
    axi_write(8'hac, 32'h00000005, 4'hf, 2'b00);
    @(negedge aclk);
    chk_val("loop_upper_ua", 32'd12700, {15'h0, loop_upper_ua});
    loop_step(6'd11, 1'b1, 1'b1);
    loop_step(6'd8, 1'b1, 1'b1);
    loop_step(6'd5, 1'b1, 1'b1);
    loop_step(6'd4, 1'b1, 1'b0);
    loop_step(6'd10, 1'b1, 1'b0);
    loop_step(6'd10, 1'b0, 1'b0);
    loop_step(6'd11, 1'b0, 1'b1);
    test_done();
  end
endmodule : lcp_param_bank_tb
